// [inc/hbb_pkg.sv]
// Package with modes, states and timing counts for the host-driven bit-bang port.
package hbb_pkg;
	localparam int          HBB_DATA_W       = 8;
	localparam logic [7:0]  HBB_MODE_OFF     = 8'h00;
	localparam logic [7:0]  HBB_MODE_FREE    = 8'h01;
	localparam logic [7:0]  HBB_MODE_LOCK    = 8'h04;
	localparam logic [7:0]  HBB_DIR_RESET    = 8'h00;
	localparam logic [7:0]  HBB_PINS_RESET   = 8'h00;
	localparam int          HBB_SETUP_CYC    = 1;
	localparam int          HBB_STROBE_CYC   = 1;
	localparam int          HBB_BAUD_DIV     = 25;
	localparam int          HBB_CNT_W        = 16;

	typedef enum logic [2:0]
	{
		HBB_IDLE   = 3'b000,
		HBB_SAMPLE = 3'b001,
		HBB_SEND   = 3'b010,
		HBB_DRIVE  = 3'b011,
		HBB_SETUP  = 3'b100,
		HBB_WSTB   = 3'b101
	} hbb_state_t;
endpackage : hbb_pkg

// [rtl/hbb_baud_gen.sv]
// Baud-rate tick generator that paces the free-running variant.
`timescale 1ns/100ps
module hbb_baud_gen
	import hbb_pkg::*;
#(
	parameter int CNT_W = HBB_CNT_W
)
(
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] divisor,
	output logic                  tick
);
	logic [CNT_W-1:0] count_ff;

	// Counts down from the divisor and gives a one-cycle tick at zero.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			count_ff <= '0;
		else if (clk_en)
		begin
			if (!run || count_ff == '0)
				count_ff <= divisor;
			else
				count_ff <= count_ff - 1'b1;
		end
	end

	assign tick = clk_en && run && (count_ff == '0);
endmodule : hbb_baud_gen

// [rtl/hbb_port.sv]
// Eight-bit bit-bang port with free-running and lockstep variants.
`timescale 1ns/100ps
// How it works
// - Free-running mode brings the sample and update strobes out on pins.
// - Free-running mode drives each host byte onto output-configured pins.
// - Each pin direction is chosen on its own.
// - Free-running bytes are paced by the baud tick.
// - Free-running pins change only on new byte plus tick; otherwise last value holds.
// - Lockstep updates pins only per host byte, then pulses the update strobe.
// - Lockstep captures pins only because a host byte was written.
// - Lockstep takes the next byte only when the host-bound buffer has room.
// - Lockstep samples before driving, so returned data lags by one byte.
// - Lockstep drops sample strobe while reading pins, then sends the sample.
// - Sample strobe then rises and outputs change to the new byte.
// - One setup cycle after driving, update strobe pulses low then high.
// - In lockstep, rising sample strobe marks that pin data has been captured.
// - Mode command carries a direction mask kept until the next command.
module hbb_port
	import hbb_pkg::*;
#(
	parameter int DATA_W = HBB_DATA_W,
	parameter int CNT_W  = HBB_CNT_W
)
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              clk_en,
	input  wire logic              mode_load,
	input  wire logic [7:0]        mode_code,
	input  wire logic [DATA_W-1:0] dir_mask,
	input  wire logic [CNT_W-1:0]  baud_divisor,
	input  wire logic              from_host_valid,
	input  wire logic [DATA_W-1:0] from_host_data,
	output logic                   from_host_ready,
	output logic                   to_host_valid,
	output logic [DATA_W-1:0]      to_host_data,
	input  wire logic              to_host_ready,
	input  wire logic [DATA_W-1:0] pin_in,
	output logic [DATA_W-1:0]      pin_out,
	output logic [DATA_W-1:0]      pin_oe,
	output logic                   read_sample_strobe_n,
	output logic                   write_update_strobe_n,
	output logic                   busy
);
	logic [7:0]        mode_ff;
	logic [DATA_W-1:0] dir_ff;
	logic [DATA_W-1:0] pin_meta_ff;
	logic [DATA_W-1:0] pin_sync_ff;
	logic [DATA_W-1:0] out_ff;
	logic [DATA_W-1:0] hold_ff;
	logic              hold_vld_ff;
	logic [DATA_W-1:0] sample_ff;
	logic              tx_vld_ff;
	logic              rstb_n_ff;
	logic              wstb_n_ff;
	hbb_state_t        state_ff;
	hbb_state_t        nxt_state;
	logic              free_mode;
	logic              lock_mode;
	logic              tick;
	logic              take_byte;

	assign free_mode = (mode_ff == HBB_MODE_FREE);
	assign lock_mode = (mode_ff == HBB_MODE_LOCK);

	hbb_baud_gen #(
		.CNT_W   (CNT_W)
	) u_baud (
		.clk     (clk),
		.reset   (reset),
		.clk_en  (clk_en),
		.run     (free_mode),
		.divisor (baud_divisor),
		.tick    (tick)
	);

	// Mode and direction mask are held until the next mode command.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			mode_ff <= HBB_MODE_OFF;
			dir_ff  <= DATA_W'(HBB_DIR_RESET);
		end
		else if (clk_en && mode_load && !busy)
		begin
			mode_ff <= mode_code;
			dir_ff  <= dir_mask;
		end
	end

	// Pin inputs pass two flip-flops before use.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
		end
		else if (clk_en)
		begin
			pin_meta_ff <= pin_in;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// Host bytes are accepted in idle state in either variant.
	assign from_host_ready = clk_en && (state_ff == HBB_IDLE) && !mode_load
		&& ((free_mode && !hold_vld_ff)
		|| (lock_mode && !tx_vld_ff && to_host_ready));
	assign take_byte = from_host_valid && from_host_ready;
	assign busy      = (state_ff != HBB_IDLE) || hold_vld_ff;

	// Free-running holding register waits for a baud tick.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			hold_ff     <= '0;
			hold_vld_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (take_byte && free_mode)
			begin
				hold_ff     <= from_host_data;
				hold_vld_ff <= 1'b1;
			end
			else if (hold_vld_ff && tick)
				hold_vld_ff <= 1'b0;
		end
	end

	// Lockstep sequence: sample, send, drive, setup, update strobe.
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			HBB_IDLE:   if (take_byte && lock_mode) nxt_state = HBB_SAMPLE;
			HBB_SAMPLE: nxt_state = HBB_SEND;
			HBB_SEND:   nxt_state = HBB_DRIVE;
			HBB_DRIVE:  nxt_state = HBB_SETUP;
			HBB_SETUP:  nxt_state = HBB_WSTB;
			HBB_WSTB:   nxt_state = HBB_IDLE;
			default:    nxt_state = HBB_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			state_ff <= HBB_IDLE;
		else if (clk_en)
			state_ff <= nxt_state;
	end

	// Lockstep keeps the host byte until after the sample is taken.
	logic [DATA_W-1:0] lock_byte_ff;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			lock_byte_ff <= '0;
		else if (clk_en && take_byte && lock_mode)
			lock_byte_ff <= from_host_data;
	end

	// Pin sample is taken before the new byte is driven.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sample_ff <= '0;
			tx_vld_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (state_ff == HBB_SAMPLE)
			begin
				sample_ff <= pin_sync_ff;
				tx_vld_ff <= 1'b1;
			end
			else if (tx_vld_ff && to_host_ready)
				tx_vld_ff <= 1'b0;
		end
	end

	assign to_host_valid = tx_vld_ff;
	assign to_host_data  = sample_ff;

	// Output register changes on tick (free) or after the sample (lockstep).
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			out_ff <= DATA_W'(HBB_PINS_RESET);
		else if (clk_en)
		begin
			if (free_mode && hold_vld_ff && tick)
				out_ff <= hold_ff;
			else if (lock_mode && state_ff == HBB_SEND)
				out_ff <= lock_byte_ff;
		end
	end

	// Strobes high by default; sample strobe low after each tick (free) or while sampling (lockstep); update strobe low while flagging an update.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rstb_n_ff <= 1'b1;
			wstb_n_ff <= 1'b1;
		end
		else if (clk_en)
		begin
			if (free_mode)
			begin
				rstb_n_ff <= ~tick;
				wstb_n_ff <= ~(hold_vld_ff && tick);
			end
			else
			begin
				rstb_n_ff <= ~(nxt_state == HBB_SAMPLE);
				wstb_n_ff <= ~(nxt_state == HBB_WSTB);
			end
		end
	end

	assign pin_out               = out_ff;
	assign pin_oe                = dir_ff;
	assign read_sample_strobe_n  = rstb_n_ff;
	assign write_update_strobe_n = wstb_n_ff;
endmodule : hbb_port

// [verif/hbb_port_assertions.sv]
// Checker with timing assertions for the bit-bang port.
`timescale 1ns/100ps
module hbb_port_checker
	import hbb_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       clk_en,
	input wire logic       mode_load,
	input wire logic [7:0] mode_code,
	input wire logic [7:0] dir_mask,
	input wire logic       from_host_valid,
	input wire logic [7:0] from_host_data,
	input wire logic       from_host_ready,
	input wire logic       to_host_valid,
	input wire logic       to_host_ready,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic       read_sample_strobe_n,
	input wire logic       write_update_strobe_n,
	input wire logic       busy
);
	logic [7:0] mode_ff;
	wire        lock = (mode_ff == HBB_MODE_LOCK);
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			mode_ff <= HBB_MODE_OFF;
		else if (clk_en && mode_load && !busy)
			mode_ff <= mode_code;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_take;
		lock && from_host_valid && from_host_ready;
	endsequence
	sequence s_update;
		!write_update_strobe_n ##1 write_update_strobe_n;
	endsequence
	AST_OFF_REFUSE: assert property (
		!lock && mode_ff != HBB_MODE_FREE |-> !from_host_ready)
		else $error("byte accepted while port is off");
	AST_TAKE_SAMPLE: assert property (s_take |-> ##[1:3] !read_sample_strobe_n)
		else $error("no sample strobe after host byte");
	AST_TAKE_RETURN: assert property (s_take |-> ##[2:3] to_host_valid)
		else $error("no returned sample after host byte");
	AST_TAKE_DRIVE: assert property (
		s_take |-> ##5 ((pin_out ^ $past(from_host_data, 5)) & pin_oe) == 8'h00)
		else $error("host byte not driven on output pins");
	AST_TAKE_WSTB: assert property (s_take |-> ##[4:6] s_update)
		else $error("update strobe missing after host byte");
	AST_RSTB_PULSE: assert property (
		$fell(read_sample_strobe_n) && clk_en |=> read_sample_strobe_n)
		else $error("sample strobe low too long");
	AST_RETURN_MARK: assert property (
		$rose(to_host_valid) |-> $rose(read_sample_strobe_n))
		else $error("sample returned without strobe rise");
	AST_FULL_REFUSE: assert property (
		lock && to_host_valid && !to_host_ready |-> !from_host_ready)
		else $error("byte accepted with sample pending");
	AST_DIR_LOAD: assert property (
		clk_en && mode_load && !busy |=> pin_oe == $past(dir_mask))
		else $error("direction not loaded");
	AST_DIR_HOLD: assert property (
		!(clk_en && mode_load && !busy) |=> $stable(pin_oe))
		else $error("direction changed without mode load");
endmodule : hbb_port_checker
bind hbb_port hbb_port_checker u_chk (.*);

// [verif/hbb_pin_model.sv]
// Model of outside logic that drives the input-configured pins.
`timescale 1ns/100ps
module hbb_pin_model
	import hbb_pkg::*;
(
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_in
);
	assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule : hbb_pin_model

// [verif/hbb_port_tb_top.sv]
// Self-checking bench for the bit-bang port.
`timescale 1ns/100ps
module hbb_port_tb_top
	import hbb_pkg::*;
;
	typedef struct packed {logic [7:0] dir, ext, data, smp, drv;} hbb_row_t;
	logic        clk = 1'b0, reset = 1'b1, mode_load = 1'b0, from_host_valid = 1'b0;
	logic        to_host_ready = 1'b1, clk_en = 1'b1, from_host_ready, to_host_valid, busy;
	logic        read_sample_strobe_n, write_update_strobe_n;
	logic [7:0]  mode_code = 8'h00, dir_mask = 8'h00, from_host_data = 8'h00, ext_val = 8'h00;
	logic [7:0]  to_host_data, pin_in, pin_out, pin_oe;
	logic [15:0] baud_divisor = 16'h0002;
	int          n_fail = 0, total_checks = 0, i, n_low = 0, n_w = 0;
	hbb_row_t    rows [4] = '{'{8'hff, 8'h00, 8'h55, 8'h00, 8'h55},
		'{8'hff, 8'h00, 8'haa, 8'h55, 8'haa}, '{8'hf0, 8'h0c, 8'h33, 8'hac, 8'h30},
		'{8'h00, 8'h5a, 8'hff, 8'h5a, 8'h00}};
	hbb_port DUT (.clk(clk), .reset(reset), .clk_en(clk_en), .mode_load(mode_load),
		.mode_code(mode_code), .dir_mask(dir_mask), .baud_divisor(baud_divisor),
		.from_host_valid(from_host_valid), .from_host_data(from_host_data),
		.from_host_ready(from_host_ready), .to_host_valid(to_host_valid),
		.to_host_data(to_host_data), .to_host_ready(to_host_ready), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .read_sample_strobe_n(read_sample_strobe_n),
		.write_update_strobe_n(write_update_strobe_n), .busy(busy));
	hbb_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in));
	initial forever #2 clk = ~clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim
	task automatic load(input logic [7:0] m, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		mode_code <= m;
		dir_mask  <= d;
		ext_val   <= e;
		mode_load <= 1'b1;
		@(posedge clk);
		mode_load <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : load
	task automatic send(input logic [7:0] d, input logic [7:0] s, input bit lk);
		@(posedge clk);
		from_host_data  <= d;
		from_host_valid <= 1'b1;
		do @(negedge clk); while (!from_host_ready);
		@(posedge clk);
		from_host_valid <= 1'b0;
		do @(negedge clk); while (lk && !to_host_valid);
		check(busy, 1'b1);
		if (lk)
			check(to_host_data, s);
		do @(negedge clk); while (busy);
	endtask : send
	task automatic count_strobes;
		n_low = 0;
		n_w   = 0;
		repeat (30)
		begin
			@(negedge clk);
			n_low += !read_sample_strobe_n;
			n_w   += !write_update_strobe_n;
		end
	endtask : count_strobes
	initial
	begin
		#20000;
		n_fail++;
		end_sim;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		check({read_sample_strobe_n, write_update_strobe_n}, 8'h03);
		check({to_host_valid, from_host_ready}, 8'h00);
		check(pin_oe, HBB_DIR_RESET);
		for (i = 0; i < 4; i++)
		begin
			load(HBB_MODE_LOCK, rows[i].dir, rows[i].ext);
			send(rows[i].data, rows[i].smp, 1'b1);
			check(pin_oe, rows[i].dir);
			check(pin_out & pin_oe, rows[i].drv);
		end
		// Leave a sample pending toward the host, then offer another byte.
		@(posedge clk);
		from_host_data  <= 8'h11;
		from_host_valid <= 1'b1;
		@(negedge clk);
		check(from_host_ready, 1'b1);
		@(posedge clk);
		from_host_valid <= 1'b0;
		to_host_ready   <= 1'b0;
		do @(negedge clk); while (busy);
		check(to_host_valid, 1'b1);
		check(to_host_data, 8'h5a);
		@(posedge clk);
		from_host_valid <= 1'b1;
		repeat (8)
		begin
			@(negedge clk);
			check(from_host_ready, 1'b0);
		end
		@(posedge clk);
		from_host_valid <= 1'b0;
		to_host_ready   <= 1'b1;
		ext_val         <= 8'h96;
		send(8'h22, 8'h96, 1'b1);
		load(HBB_MODE_FREE, 8'hff, 8'h00);
		@(posedge clk);
		from_host_data  <= 8'h3c;
		from_host_valid <= 1'b1;
		@(negedge clk);
		check(from_host_ready, 1'b1);
		@(posedge clk);
		from_host_valid <= 1'b0;
		count_strobes;
		check({n_low[3:0], n_w[3:0]}, 8'ha1);
		check(pin_out, 8'h3c);
		count_strobes;
		check({n_low[3:0], n_w[3:0]}, 8'ha0);
		check(pin_out, 8'h3c);
		// A low clock enable freezes the port and refuses host bytes.
		@(posedge clk);
		clk_en          <= 1'b0;
		from_host_data  <= 8'hc3;
		from_host_valid <= 1'b1;
		count_strobes;
		check(n_w[7:0], 8'h00);
		check(from_host_ready, 1'b0);
		check(pin_out, 8'h3c);
		@(posedge clk);
		clk_en          <= 1'b1;
		from_host_valid <= 1'b0;
		// A reset in mid-run clears the pins and the port works again after it.
		@(posedge clk);
		reset <= 1'b1;
		@(negedge clk);
		check(pin_out | pin_oe, 8'h00);
		@(posedge clk);
		reset <= 1'b0;
		load(HBB_MODE_LOCK, 8'h0f, 8'ha5);
		send(8'h96, 8'ha0, 1'b1);
		check(pin_out & pin_oe, 8'h06);
		end_sim;
	end
endmodule : hbb_port_tb_top
